/* design/pg_mask_bank.sv */
`default_nettype none

// Power-good mask register bank driving output pins four and two
module pg_mask_bank
	import pg_mask_pkg::*;
#(
	parameter variant_t VARIANT = VARIANT_A
) (
	input wire logic CLK_I,                  // Register clock, 50 MHz
	input wire logic RESET_N_I,              // Async reset, active low
	input wire logic CE_I,                   // Clock enable, low freezes all state
	input wire logic REG_WR_I,               // Register write strobe
	input wire logic REG_RD_I,               // Register read strobe
	input wire logic [7:0] REG_ADDR_I,       // Register offset
	input wire logic [7:0] REG_WDATA_I,      // Register write data
	output logic [7:0] REG_RDATA_O,          // Register read data
	input wire logic [5:0] STEP_DOWN_PG_I,   // Step-down rails six..one, bit 5 is six
	input wire logic AUX_LDO_TWO_PG_I,       // Aux LDO two good
	input wire logic SWITCH_A_ONE_PG_I,      // Load switch A one good
	input wire logic [3:0] ENABLE_IN_I,      // Enable inputs five, four, two, one
	input wire logic TERMINATION_LDO_PG_I,   // Memory-termination LDO good
	input wire logic SHARED_SRC_PG_I,        // Switch B two or aux LDO one good
	input wire logic SWITCH_B_ONE_PG_I,      // Load switch B one good
	input wire logic AUX_LDO_THREE_PG_I,     // Aux LDO three good
	output logic PG_OUTPUT_FOUR_O,           // Pin-four power good
	output logic PG_OUTPUT_TWO_O             // Pin-two power good, rails part
);

	localparam int NSRC = 16;                      // Status bits into the trees
	localparam mask_bank_t BANK_RST = reset_bank(VARIANT); // Variant defaults

	// Raw pin-side status in the same order as the two mask registers
	logic [NSRC-1:0] status_raw;  // Unsynchronised status
	logic [NSRC-1:0] sync_first;  // First synchroniser stage
	logic [NSRC-1:0] sync_second; // Second stage, safe to read
	mask_bank_t bank;             // Mask registers
	mask_bank_t next_bank;        // Next mask registers
	reg_req_t req;                // Current register access
	logic [7:0] rdata;            // Read data register
	logic [7:0] next_rdata;       // Next read data
	logic good_four;              // Pin-four tree result
	logic good_two;               // Pin-two tree result
	logic pg_four;                // Pin-four output register
	logic pg_two;                 // Pin-two output register
	logic next_pg_four;           // Next pin-four output
	logic next_pg_two;            // Next pin-two output

	// Bits 15..8 pair with the first register, 7..0 with the second
	// Aux LDO two source
	assign status_raw[8 + POS_MASK_AUX_LDO_TWO] = AUX_LDO_TWO_PG_I;
	assign status_raw[8 + POS_MASK_SWITCH_A_ONE] = SWITCH_A_ONE_PG_I;
	assign status_raw[8 + POS_MASK_STEP_DOWN_SIX:8 + POS_MASK_STEP_DOWN_ONE] = STEP_DOWN_PG_I;
	assign status_raw[POS_MASK_ENABLE_INPUT_FIVE:POS_MASK_ENABLE_INPUT_ONE] = ENABLE_IN_I;
	assign status_raw[POS_MASK_TERMINATION_LDO] = TERMINATION_LDO_PG_I;
	assign status_raw[POS_MASK_SHARED_SWITCH_OR_LDO] = SHARED_SRC_PG_I;
	assign status_raw[POS_MASK_SWITCH_B_ONE] = SWITCH_B_ONE_PG_I;
	assign status_raw[POS_MASK_AUX_LDO_THREE] = AUX_LDO_THREE_PG_I;

	// Bundle the register port into one access
	assign req = '{REG_WR_I, REG_RD_I, REG_ADDR_I, REG_WDATA_I};

	// Two-flop synchroniser per status bit; reset reads as not good
	genvar gi;
	generate
		for (gi = 0; gi < NSRC; gi++) begin : g_sync
			always_ff @(posedge CLK_I or negedge RESET_N_I) begin
				if (!RESET_N_I) begin
					sync_first[gi] <= 1'b0;
					sync_second[gi] <= 1'b0;
				end else if (CE_I) begin
					// Second stage reads only the first stage
					sync_first[gi] <= status_raw[gi];
					sync_second[gi] <= sync_first[gi];
				end
			end
		end
	endgenerate

	// Register writes and reads, next-value side
	always_comb begin
		next_bank = bank;
		next_rdata = rdata;
		if (req.wr) begin
			unique case (req.addr)
				OFS_OUT4_PG_MASK_RAILS_A: begin
					next_bank.out4_a = req.data;
				end
				OFS_OUT4_PG_MASK_RAILS_B: begin
					next_bank.out4_b = req.data;
				end
				OFS_OUT2_PG_MASK_RAILS_A: begin
					next_bank.out2_a = req.data;
				end
				default: begin
					// Unmapped write is dropped
					next_bank = bank;
				end
			endcase
		end
		if (req.rd) begin
			unique case (req.addr)
				OFS_OUT4_PG_MASK_RAILS_A: begin
					next_rdata = bank.out4_a;
				end
				OFS_OUT4_PG_MASK_RAILS_B: begin
					next_rdata = bank.out4_b;
				end
				OFS_OUT2_PG_MASK_RAILS_A: begin
					next_rdata = bank.out2_a;
				end
				default: begin
					// Unmapped read returns zero
					next_rdata = RD_UNMAPPED;
				end
			endcase
		end
	end

	// Register storage; reset loads the variant defaults
	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			bank <= BANK_RST;
			rdata <= RD_UNMAPPED;
		end else if (CE_I) begin
			bank <= next_bank;
			rdata <= next_rdata;
		end
	end

	// Pin-four tree over both of its mask registers
	// Pin-four combine
	pg_tree_gate #(
		.WIDTH(NSRC)
	) u_tree_four (
		.status_i(sync_second),
		.mask_i({bank.out4_a, bank.out4_b}),
		.good_o(good_four)
	);

	// Pin-two tree over its first register's sources
	// Eight bits, same layout as the pin-four rails register only
	pg_tree_gate #(
		.WIDTH(8)
	) u_tree_two (
		.status_i(sync_second[NSRC-1:8]),
		.mask_i(bank.out2_a),
		.good_o(good_two)
	);

	// Output next values straight from the trees
	always_comb begin
		next_pg_four = good_four;
		next_pg_two = good_two;
	end

	// Output registers; one edge after a mask write lands
	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			pg_four <= 1'b0;
			pg_two <= 1'b0;
		end else if (CE_I) begin
			pg_four <= next_pg_four;
			pg_two <= next_pg_two;
		end
	end

	// Outputs come straight from flip-flops
	assign REG_RDATA_O = rdata;
	assign PG_OUTPUT_FOUR_O = pg_four;
	assign PG_OUTPUT_TWO_O = pg_two;

endmodule // pg_mask_bank

`default_nettype wire

/* common/pg_mask_pkg.sv */
`default_nettype none

package pg_mask_pkg;

	// Register offsets on the serial control register port
	localparam logic [7:0] OFS_OUT4_PG_MASK_RAILS_A = 8'ha6;
	localparam logic [7:0] OFS_OUT4_PG_MASK_RAILS_B = 8'ha7;
	localparam logic [7:0] OFS_OUT2_PG_MASK_RAILS_A = 8'ha8;

	// Field positions, first-type register (rails)
	localparam int POS_MASK_AUX_LDO_TWO = 7;
	localparam int POS_MASK_SWITCH_A_ONE = 6;
	localparam int POS_MASK_STEP_DOWN_SIX = 5;
	localparam int POS_MASK_STEP_DOWN_ONE = 0;

	// Field positions, second-type register
	localparam int POS_MASK_ENABLE_INPUT_FIVE = 7;
	localparam int POS_MASK_ENABLE_INPUT_FOUR = 6;
	localparam int POS_MASK_ENABLE_INPUT_TWO = 5;
	localparam int POS_MASK_ENABLE_INPUT_ONE = 4;
	localparam int POS_MASK_TERMINATION_LDO = 3;
	localparam int POS_MASK_SHARED_SWITCH_OR_LDO = 2;
	localparam int POS_MASK_SWITCH_B_ONE = 1;
	localparam int POS_MASK_AUX_LDO_THREE = 0;

	// Factory variants; the variant picks only the mask reset values
	typedef enum logic [1:0] {
		VARIANT_A = 2'h0,
		VARIANT_B = 2'h1,
		VARIANT_C = 2'h2,
		VARIANT_D = 2'h3
	} variant_t;

	// Per-variant reset values, register A6
	localparam logic [7:0] RST_OUT4_A_VAR_A = 8'hf7;
	localparam logic [7:0] RST_OUT4_A_VAR_B = 8'hbf;
	localparam logic [7:0] RST_OUT4_A_VAR_C = 8'hf7;
	localparam logic [7:0] RST_OUT4_A_VAR_D = 8'hff;
	// Per-variant reset values, register A7
	localparam logic [7:0] RST_OUT4_B_VAR_A = 8'hbf;
	localparam logic [7:0] RST_OUT4_B_VAR_B = 8'hff;
	localparam logic [7:0] RST_OUT4_B_VAR_C = 8'h7f;
	localparam logic [7:0] RST_OUT4_B_VAR_D = 8'hff;
	// Per-variant reset values, register A8
	localparam logic [7:0] RST_OUT2_A_VAR_A = 8'hdf;
	localparam logic [7:0] RST_OUT2_A_VAR_B = 8'heb;
	localparam logic [7:0] RST_OUT2_A_VAR_C = 8'hdf;
	localparam logic [7:0] RST_OUT2_A_VAR_D = 8'hc0;

	// Value read back from an unmapped offset
	localparam logic [7:0] RD_UNMAPPED = 8'h00;

	// Synchroniser depth for pin-side status inputs
	localparam int SYNC_STAGES = 2;

	// One register access from the serial control interface
	typedef struct packed {
		logic wr;         // Write strobe
		logic rd;         // Read strobe
		logic [7:0] addr; // Register offset
		logic [7:0] data; // Write data
	} reg_req_t;

	// The three mask registers of this bank
	typedef struct packed {
		logic [7:0] out4_a; // Pin-four rails mask
		logic [7:0] out4_b; // Pin-four enables and LDO mask
		logic [7:0] out2_a; // Pin-two rails mask
	} mask_bank_t;

	// Reset value of the bank for a variant
	function automatic mask_bank_t reset_bank(input variant_t v);
		mask_bank_t r;
		r = '0;
		unique case (v)
			VARIANT_A: r = '{RST_OUT4_A_VAR_A, RST_OUT4_B_VAR_A, RST_OUT2_A_VAR_A};
			VARIANT_B: r = '{RST_OUT4_A_VAR_B, RST_OUT4_B_VAR_B, RST_OUT2_A_VAR_B};
			VARIANT_C: r = '{RST_OUT4_A_VAR_C, RST_OUT4_B_VAR_C, RST_OUT2_A_VAR_C};
			VARIANT_D: r = '{RST_OUT4_A_VAR_D, RST_OUT4_B_VAR_D, RST_OUT2_A_VAR_D};
		endcase
		return r;
	endfunction

endpackage

`default_nettype wire

/* design/pg_tree_gate.sv */
`default_nettype none

// Combines status bits with their masks into one good level
module pg_tree_gate #(
	parameter int WIDTH = 16
) (
	input wire logic [WIDTH-1:0] status_i, // Source good levels, high is good
	input wire logic [WIDTH-1:0] mask_i,   // One ignores the source
	output logic good_o                    // High when every unmasked source good
);

	// Masked sources count as good; all masked gives good
	// AND of unmasked
	assign good_o = &(status_i | mask_i);

endmodule // pg_tree_gate

`default_nettype wire

/* tb/pg_src_model.sv */
`default_nettype none
// Power sources seen by the bank, launched just after each edge
module pg_src_model (
	input wire logic CLK_I, // Register clock
	input wire logic [15:0] good_i, // Wanted source levels
	output logic [15:0] src_o // Source levels to the bank
);
	timeunit 1ns;
	timeprecision 1ns;
	// Levels move only after an edge, like real rails
	always_ff @(posedge CLK_I) src_o <= good_i;
endmodule // pg_src_model
`default_nettype wire

/* tb/pg_mask_chk.sv */
`default_nettype none
// Checks the tree outputs and register port of the bank
module pg_mask_chk (
	input wire logic CLK_I, // Clock
	input wire logic RESET_N_I, // Reset, active low
	input wire logic CE_I, // Clock enable
	input wire logic REG_WR_I, // Write strobe
	input wire logic REG_RD_I, // Read strobe
	input wire logic [7:0] REG_ADDR_I, // Offset
	input wire logic [7:0] REG_WDATA_I, // Write data
	input wire logic [7:0] REG_RDATA_O, // Read data
	input wire logic [5:0] STEP_DOWN_PG_I, // Rails
	input wire logic AUX_LDO_TWO_PG_I, // Source
	input wire logic SWITCH_A_ONE_PG_I, // Source
	input wire logic [3:0] ENABLE_IN_I, // Enables
	input wire logic TERMINATION_LDO_PG_I, // Source
	input wire logic SHARED_SRC_PG_I, // Source
	input wire logic SWITCH_B_ONE_PG_I, // Source
	input wire logic AUX_LDO_THREE_PG_I, // Source
	input wire logic PG_OUTPUT_FOUR_O, // Pin four
	input wire logic PG_OUTPUT_TWO_O // Pin two
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [23:0] m; // Mirror of written masks
	logic [2:0] kn; // Mirror entries known
	logic [2:0] h; // Recent clock enables
	wire logic [15:0] s = {AUX_LDO_TWO_PG_I, SWITCH_A_ONE_PG_I, STEP_DOWN_PG_I, ENABLE_IN_I,
		TERMINATION_LDO_PG_I, SHARED_SRC_PG_I, SWITCH_B_ONE_PG_I, AUX_LDO_THREE_PG_I};
	// Mirror writes; the design's defaults stay unknown here
	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			kn <= 3'h0;
			h <= 3'h0;
		end else begin
			h <= {h[1:0], CE_I};
			for (int j = 0; j < 3; j++) begin
				if (CE_I && REG_WR_I && REG_ADDR_I == 8'ha6 + 8'(j)) begin
					m[23 - 8 * j -: 8] <= REG_WDATA_I;
					kn[2 - j] <= 1'b1;
				end
			end
		end
	end
	// Read data expected for an offset
	function automatic logic [7:0] rv(input logic [7:0] a, input logic [23:0] v);
		return a == 8'ha6 ? v[23:16] : a == 8'ha7 ? v[15:8] : a == 8'ha8 ? v[7:0] : 8'h00;
	endfunction
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RESET_N_I);
	// Unmasked bad source in a field forces pin four low
	property g(logic [15:0] f);
		&h && $past(&kn) && |(f & ~($past(m[23:8]) | $past(s, 3))) |-> !PG_OUTPUT_FOUR_O;
	endproperty
	a_four_tree: assert property (&h && $past(&kn)
		|-> PG_OUTPUT_FOUR_O == &($past(m[23:8]) | $past(s, 3))) else $error("pin four tree");
	a_two_tree: assert property (&h && $past(&kn)
		|-> PG_OUTPUT_TWO_O == &($past(m[7:0]) | $past(s[15:8], 3))) else $error("pin two tree");
	a_rails_gate: assert property (g(16'hff00)) else $error("rail gate");
	a_enable_gate: assert property (g(16'h00f0)) else $error("enable gate");
	a_ldo_gate: assert property (g(16'h0009)) else $error("ldo gate");
	a_switch_gate: assert property (g(16'h0006)) else $error("switch gate");
	a_read_back: assert property ($past(REG_RD_I && CE_I && &kn)
		|-> REG_RDATA_O == rv($past(REG_ADDR_I), $past(m))) else $error("read data");
	a_rdata_hold: assert property (!$past(REG_RD_I && CE_I)
		|-> $stable(REG_RDATA_O)) else $error("read data moved");
	c_write_b: cover property (CE_I && REG_WR_I && REG_ADDR_I == 8'ha7);
	c_four_low: cover property ($fell(PG_OUTPUT_FOUR_O));
	c_rd_unmapped: cover property (REG_RD_I && REG_ADDR_I == 8'ha9);
	c_two_low: cover property ($fell(PG_OUTPUT_TWO_O));
endmodule // pg_mask_chk
`default_nettype wire

/* tb/tb.sv */
`default_nettype none
// Register and tree tests for the mask bank
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_n, ce, wr, rd, pg4, pg2; // Clock, controls, outputs
	logic [7:0] addr, wd, rdata; // Register port
	logic [15:0] good, src, mm; // Wanted levels, sources, masks
	int failures, comparisons; // Counters
	pg_mask_bank pg_mask_bank_inst (.CLK_I(clk), .RESET_N_I(rst_n), .CE_I(ce), .REG_WR_I(wr),
		.REG_RD_I(rd), .REG_ADDR_I(addr), .REG_WDATA_I(wd), .REG_RDATA_O(rdata),
		.STEP_DOWN_PG_I(src[13:8]), .AUX_LDO_TWO_PG_I(src[15]), .SWITCH_A_ONE_PG_I(src[14]),
		.ENABLE_IN_I(src[7:4]), .TERMINATION_LDO_PG_I(src[3]), .SHARED_SRC_PG_I(src[2]),
		.SWITCH_B_ONE_PG_I(src[1]), .AUX_LDO_THREE_PG_I(src[0]), .PG_OUTPUT_FOUR_O(pg4),
		.PG_OUTPUT_TWO_O(pg2));
	pg_src_model pg_src_model_inst (.CLK_I(clk), .good_i(good), .src_o(src));
	// Free-running clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Verdict and end of run
	task end_sim;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Compare seen with expected
	task chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %0t got %h want %h", $time, got, exp);
		end
	endtask
	// One write cycle
	task wr_r(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wd <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// One read cycle, data checked after the taking edge
	task rd_r(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask
	// Let sources settle through the synchroniser, then check both pins
	task pg(input logic e4, input logic e2);
		repeat (4) @(posedge clk);
		#1 chk({6'h00, pg4, pg2}, {6'h00, e4, e2});
	endtask
	// Write all three masks
	task masks(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
		wr_r(8'ha6, a);
		wr_r(8'ha7, b);
		wr_r(8'ha8, c);
	endtask
	// Hang guard
	initial begin
		#1000000;
		failures++;
		end_sim;
	end
	// Main sequence
	initial begin
		{rst_n, wr, rd, addr, wd} = '0;
		ce = 1'b1;
		good = 16'hffff;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd_r(8'ha6, 8'hf7);
		rd_r(8'ha7, 8'hbf);
		rd_r(8'ha8, 8'hdf);
		rd_r(8'ha9, 8'h00);
		pg(1'b1, 1'b1);
		$display("test defaults done");
		// One bad source at a time, unmasked then masked by its own bit
		for (int k = 0; k < 2; k++) begin
			for (int i = 0; i < 16; i++) begin
				mm = k ? 16'h0001 << i : 16'h0000;
				// Pin two gets the inverse rails mask, so only its own register fits
				masks(mm[15:8], mm[7:0], ~mm[15:8]);
				rd_r(8'ha7, mm[7:0]);
				good <= ~(16'h0001 << i);
				pg(k == 1, k == 0 || i < 8);
			end
		end
		$display("test sweep done");
		masks(8'hff, 8'hff, 8'hff);
		good <= 16'h0000;
		pg(1'b1, 1'b1);
		$display("test all masked done");
		// Frozen enable and unmapped offsets leave the bank alone
		// Controls move only on a rising edge
		@(posedge clk);
		ce <= 1'b0;
		wr_r(8'ha6, 8'h5a);
		ce <= 1'b1;
		wr_r(8'ha9, 8'h5a);
		rd_r(8'ha9, 8'h00);
		rd_r(8'ha6, 8'hff);
		@(posedge clk);
		rst_n <= 1'b0;
		@(posedge clk);
		rst_n <= 1'b1;
		rd_r(8'ha6, 8'hf7);
		$display("test refuse and reset done");
		end_sim;
	end
endmodule // tb
// Checker on every bank instance, outside the bench module
bind pg_mask_bank pg_mask_chk pg_mask_chk_inst (.*);
`default_nettype wire
